// ### rtl/bfs_defines.svh
`ifndef BFS_DEFINES_SVH
`define BFS_DEFINES_SVH

// Clock and the 1 us timebase tick
`define BF_CLK_NS     8
`define BF_TICK_NS    1000
`define BF_TICK_CYC   (`BF_TICK_NS / `BF_CLK_NS)

// Timer figures; one timebase tick is one microsecond
`define BF_MS2TK(m)   ((m) * 1000)
`define BF_T130_US    130
`define BF_T620_US    620
`define BF_T80_MS     80
`define BF_TFU_MS     100
`define BF_TFLT_MS    200
`define BF_TOV_MS     625
`define BF_TDC_MS     2500
`define BF_PFC_STOP_US 5

// Preheat quantisation
`define BF_PH_MAX_MS  2500
`define BF_PH_STEPS   127
`define BF_PH_STEP_US ((`BF_PH_MAX_MS * 1000) / `BF_PH_STEPS)

// Fault-U retry limit
`define BF_FU_MAX     7

// Dead time, least rounded up, longest rounded down
`define BF_DT_MIN_NS  1050
`define BF_DT_MAX_NS  2000
`define BF_DT_MIN_CYC ((`BF_DT_MIN_NS + `BF_CLK_NS - 1) / `BF_CLK_NS)
`define BF_DT_MAX_CYC (`BF_DT_MAX_NS / `BF_CLK_NS)

// Timer counter width
`define BF_TW         22

`endif

// ### rtl/bfs_pkg.sv
package bfs_pkg;

	typedef enum logic [3:0] {
		ST_LOCK,
		ST_HYST,
		ST_W130,
		ST_START,
		ST_PREHT,
		ST_RUN,
		ST_FUW,
		ST_FLTW,
		ST_LATCH
	} bfs_state_t;

endpackage : bfs_pkg

// ### rtl/bfs_filt.sv
`timescale 1ns/1ps
`include "bfs_defines.svh"

module bfs_filt (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                tick,
	input  wire logic                cond,
	input  wire logic [`BF_TW-1:0]   limit,
	output logic                     done
);

	logic [`BF_TW-1:0] cnt_r;

	assign done = cond && (cnt_r >= limit);

	// Any drop of the condition restarts the filter from zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= '0;
		else if (!cond)
			cnt_r <= '0;
		else if (tick && !done)
			cnt_r <= cnt_r + `BF_TW'(1);
	end

	a_filt_restart: assert property (@(posedge mclk) disable iff (!rst_n)
		!cond |=> cnt_r == '0)
		else $error("filter timer not restarted");

endmodule : bfs_filt

// ### rtl/bfs_dtime.sv
`timescale 1ns/1ps
`include "bfs_defines.svh"

module bfs_dtime (
	input  wire logic   mclk,
	input  wire logic   rst_n,
	input  wire logic   en,
	input  wire logic   phase,
	input  wire logic   valley,
	output logic        upper_r,
	output logic        lower_r
);

	localparam logic [7:0] DT_MIN = 8'(`BF_DT_MIN_CYC);
	localparam logic [7:0] DT_MAX = 8'(`BF_DT_MAX_CYC);

	logic [7:0] gap_r;
	wire want_up = en & phase;
	wire want_lo = en & ~phase;
	wire busy    = upper_r | lower_r;
	wire chg     = (upper_r != want_up) | (lower_r != want_lo);
	wire gap_min = gap_r >= DT_MIN;
	wire gap_max = gap_r >= DT_MAX;
	// Valley seen early still waits for the least dead time
	wire fire    = chg & ~busy & (gap_max | (gap_min & valley));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			upper_r <= 1'b0;
			lower_r <= 1'b0;
			gap_r   <= 8'h00;
		end else if (chg && busy) begin
			upper_r <= 1'b0;
			lower_r <= 1'b0;
			gap_r   <= 8'h00;
		end else if (fire) begin
			upper_r <= want_up;
			lower_r <= want_lo;
		end else if (!gap_max) begin
			gap_r <= gap_r + 8'h01;
		end
	end

	a_dead_min: assert property (@(posedge mclk) disable iff (!rst_n)
		($rose(upper_r) || $rose(lower_r)) |-> $past(gap_r) >= DT_MIN)
		else $error("dead time shorter than minimum");

	a_dead_max: assert property (@(posedge mclk) disable iff (!rst_n)
		(chg && !busy && gap_max) |=> busy)
		else $error("dead time longer than maximum");

	a_no_overlap: assert property (@(posedge mclk) disable iff (!rst_n)
		!(upper_r && lower_r))
		else $error("both gate drives on");

	a_off_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
		!en |=> !upper_r && !lower_r)
		else $error("gate drive on while disabled");

endmodule : bfs_dtime

// ### rtl/bfs_supervisor.sv
// Operation
// - Overvoltage in run stops PFC drive fast
// - PFC drive resumes once bus below 105%
// - Overvoltage past 625ms is inverter overvoltage
// - Bus levels 12.5/75/95/109% are separate conditions
// - Fault U: power down, 100ms, recheck, restart
// - Fault U waits repeat at most seven times
// - Fault U restart skips preheat, later ones not
// - Preheat time in 127 steps to 2500ms
// - Filament open above 1.6V, low threshold after
// - Open filament blocks start until below 1.3V
// - No lamp sink current selects high currents
// - Restart level above 3.2V 620us latches
// - Fault: gates off, 200ms, then second attempt
// - Failed second attempt latches until removal
// - Grounded restart pin disables its function
// - Lamp AC overcurrent 620us is end of life
// - Lamp DC overcurrent 2500ms is rectifier fault
// - Grounded lamp input re-enabled in run
// - Damping switch only in extended off-time
// - Adaptive dead time 1.05 to 2.0us
// - Gate drives low during supply lockout
// - Wait 130us after start threshold, check bus
// - Bus must reach 95% within 80ms
`timescale 1ns/1ps
`include "bfs_defines.svh"

module bfs_supervisor #(
	parameter logic [`BF_TW-1:0] T_130  = `BF_TW'(`BF_T130_US),
	parameter logic [`BF_TW-1:0] T_620  = `BF_TW'(`BF_T620_US),
	parameter logic [`BF_TW-1:0] T_80   = `BF_TW'(`BF_MS2TK(`BF_T80_MS)),
	parameter logic [`BF_TW-1:0] T_FU   = `BF_TW'(`BF_MS2TK(`BF_TFU_MS)),
	parameter logic [`BF_TW-1:0] T_FLT  = `BF_TW'(`BF_MS2TK(`BF_TFLT_MS)),
	parameter logic [`BF_TW-1:0] T_OV   = `BF_TW'(`BF_MS2TK(`BF_TOV_MS)),
	parameter logic [`BF_TW-1:0] T_DC   = `BF_TW'(`BF_MS2TK(`BF_TDC_MS)),
	parameter logic [`BF_TW-1:0] PH_STP = `BF_TW'(`BF_PH_STEP_US)
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         supply_lockout,
	input  wire logic         supply_start,
	input  wire logic         bus_above_open,
	input  wire logic         bus_above_under,
	input  wire logic         bus_above_start,
	input  wire logic         bus_above_resume,
	input  wire logic         bus_above_ov,
	input  wire logic         res_above_thr,
	input  wire logic         res_above_latch,
	input  wire logic         res_grounded,
	input  wire logic         lamp_sense_first_sink,
	input  wire logic         lamp_sense_second_sink,
	input  wire logic         lamp_sense_first_low,
	input  wire logic         lamp_sense_second_low,
	input  wire logic         lamp_sense_first_en_lvl,
	input  wire logic         lamp_sense_second_en_lvl,
	input  wire logic         lamp_sense_first_ac_over,
	input  wire logic         lamp_sense_second_ac_over,
	input  wire logic         lamp_sense_first_dc_over,
	input  wire logic         lamp_sense_second_dc_over,
	input  wire logic [6:0]   preheat_time_set,
	input  wire logic         half_bridge_phase,
	input  wire logic         bridge_valley,
	input  wire logic         pfc_gate_req,
	input  wire logic         pfc_dcm_offtime,
	output logic              upper_gate_drive,
	output logic              lower_gate_drive,
	output logic              pfc_gate_drive,
	output logic              damping_switch,
	output logic              res_thr_low_sel,
	output logic              res_current_high_sel,
	output logic              res_current_reduced_sel,
	output logic              filament_open,
	output logic              end_of_life_fault,
	output logic              rectifier_effect_fault,
	output logic              latched_fault,
	output logic              run_mode,
	output logic              preheat_active
);

	localparam logic [6:0] TICK_LAST = 7'(`BF_TICK_CYC - 1);
	localparam logic [2:0] FU_MAX    = 3'(`BF_FU_MAX);

	bfs_pkg::bfs_state_t st_r;
	bfs_pkg::bfs_state_t st_nxt;

	logic [6:0]  div_r;
	logic [2:0]  fu_cnt_r;
	logic [2:0]  fu_nxt;
	logic        skip_r;
	logic        skip_nxt;
	logic        retry_r;
	logic        retry_nxt;
	logic        fil_open_r;
	logic        res_dis_r;
	logic        hs_open_r;
	logic [1:0]  lamp_en_r;
	logic        pfc_stop_r;
	logic        pfc_gate_r;
	logic        damping_r;
	logic        end_of_life_fault_r;
	logic        rectifier_effect_fault_r;
	logic        latched_r;
	logic        run_r;
	logic        preht_r;
	logic        wait_clr_r;
	logic        t130_done;
	logic        t80_done;
	logic        tov_done;
	logic        wait_done;
	logic        res_done;
	logic        end_of_life_fault_done;
	logic        rectifier_effect_fault_done;
	logic        tph_done;

	wire tick     = div_r == TICK_LAST;
	wire in_run   = st_r == bfs_pkg::ST_RUN;
	wire in_wait  = st_r == bfs_pkg::ST_FUW ||
		st_r == bfs_pkg::ST_FLTW;
	wire inv_en   = st_r == bfs_pkg::ST_START ||
		st_r == bfs_pkg::ST_PREHT || in_run;
	wire pfc_en   = inv_en && !pfc_stop_r;
	wire ov_run   = in_run && bus_above_ov;
	wire fil_set  = !res_dis_r && !fil_open_r && res_above_thr &&
		st_r != bfs_pkg::ST_LOCK;
	wire fil_clr  = fil_open_r && !res_above_thr;
	// Start needs bus inside 12.5..105% and both filaments present
	wire start_ok = bus_above_open && !bus_above_resume &&
		!fil_open_r && !fil_set;
	wire ac_any   = |(lamp_en_r & {lamp_sense_second_ac_over,
		lamp_sense_first_ac_over});
	wire dc_any   = |(lamp_en_r & {lamp_sense_second_dc_over,
		lamp_sense_first_dc_over});
	wire lamp_snk = |(lamp_en_r & {lamp_sense_second_sink,
		lamp_sense_first_sink});
	wire enter_st = st_nxt == bfs_pkg::ST_START &&
		st_r != bfs_pkg::ST_START;
	wire [`BF_TW-1:0] wait_lim = (st_r == bfs_pkg::ST_FUW) ? T_FU : T_FLT;
	wire [`BF_TW-1:0] ph_lim = PH_STP *
		{15'h0000, preheat_time_set};

	bfs_filt u_t130 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (st_r == bfs_pkg::ST_W130),
		.limit (T_130),
		.done  (t130_done)
	);

	bfs_filt u_t80 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (st_r == bfs_pkg::ST_START),
		.limit (T_80),
		.done  (t80_done)
	);

	bfs_filt u_tov (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (ov_run),
		.limit (T_OV),
		.done  (tov_done)
	);

	// Wait timer drops its condition for one cycle to re-arm
	bfs_filt u_twait (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (in_wait && !wait_clr_r),
		.limit (wait_lim),
		.done  (wait_done)
	);

	bfs_filt u_tres (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (in_run && res_above_latch && !res_dis_r),
		.limit (T_620),
		.done  (res_done)
	);

	bfs_filt u_teol1 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (in_run && ac_any),
		.limit (T_620),
		.done  (end_of_life_fault_done)
	);

	bfs_filt u_teol2 (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (in_run && dc_any),
		.limit (T_DC),
		.done  (rectifier_effect_fault_done)
	);

	bfs_filt u_tph (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick),
		.cond  (st_r == bfs_pkg::ST_PREHT),
		.limit (ph_lim),
		.done  (tph_done)
	);

	bfs_dtime u_dtime (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.en      (inv_en && !supply_lockout),
		.phase   (half_bridge_phase),
		.valley  (bridge_valley),
		.upper_r (upper_gate_drive),
		.lower_r (lower_gate_drive)
	);

	always_comb begin
		st_nxt    = st_r;
		fu_nxt    = fu_cnt_r;
		skip_nxt  = skip_r;
		retry_nxt = retry_r;
		case (st_r)
		bfs_pkg::ST_LOCK: st_nxt = bfs_pkg::ST_HYST;
		bfs_pkg::ST_HYST: if (supply_start) begin
			st_nxt = bfs_pkg::ST_W130;
		end
		bfs_pkg::ST_W130: if (t130_done) begin
			st_nxt = start_ok ? bfs_pkg::ST_START
				: bfs_pkg::ST_HYST;
		end
		bfs_pkg::ST_START: if (bus_above_start) begin
			st_nxt   = skip_r ? bfs_pkg::ST_RUN
				: bfs_pkg::ST_PREHT;
			skip_nxt = 1'b0;
		end else if (t80_done || !bus_above_open) begin
			if (skip_r && fu_cnt_r < FU_MAX) begin
				st_nxt = bfs_pkg::ST_FUW;
			end else begin
				st_nxt    = retry_r ? bfs_pkg::ST_LATCH
					: bfs_pkg::ST_FLTW;
				retry_nxt = 1'b1;
				skip_nxt  = 1'b0;
			end
		end
		bfs_pkg::ST_PREHT: if (tph_done) begin
			st_nxt = bfs_pkg::ST_RUN;
		end
		bfs_pkg::ST_RUN: if (res_done) begin
			st_nxt = bfs_pkg::ST_LATCH;
		end else if (!bus_above_under || tov_done) begin
			st_nxt   = bfs_pkg::ST_FUW;
			fu_nxt   = 3'h0;
			skip_nxt = 1'b1;
		end else if (end_of_life_fault_done || rectifier_effect_fault_done) begin
			st_nxt    = retry_r ? bfs_pkg::ST_LATCH
				: bfs_pkg::ST_FLTW;
			retry_nxt = 1'b1;
		end
		bfs_pkg::ST_FUW: if (wait_done) begin
			fu_nxt = fu_cnt_r + 3'h1;
			if (start_ok) begin
				st_nxt = bfs_pkg::ST_START;
			end else if (fu_cnt_r == FU_MAX - 3'h1) begin
				st_nxt    = retry_r ? bfs_pkg::ST_LATCH
					: bfs_pkg::ST_FLTW;
				retry_nxt = 1'b1;
				skip_nxt  = 1'b0;
			end
		end
		bfs_pkg::ST_FLTW: if (wait_done && start_ok) begin
			st_nxt = bfs_pkg::ST_START;
		end
		bfs_pkg::ST_LATCH: if (fil_set) begin
			// A newly open filament means the lamp was pulled
			st_nxt    = bfs_pkg::ST_HYST;
			retry_nxt = 1'b0;
		end
		default: st_nxt = bfs_pkg::ST_LOCK;
		endcase
		if (supply_lockout) begin
			st_nxt    = bfs_pkg::ST_LOCK;
			fu_nxt    = 3'h0;
			skip_nxt  = 1'b0;
			retry_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= bfs_pkg::ST_LOCK;
			fu_cnt_r   <= 3'h0;
			skip_r     <= 1'b0;
			retry_r    <= 1'b0;
			div_r      <= 7'h00;
			wait_clr_r <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			fu_cnt_r   <= fu_nxt;
			skip_r     <= skip_nxt;
			retry_r    <= retry_nxt;
			div_r      <= tick ? 7'h00 : div_r + 7'h01;
			wait_clr_r <= wait_done;
		end
	end

	// Restart-sense pin: grounding disables it until lockout
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			res_dis_r  <= 1'b0;
			fil_open_r <= 1'b0;
		end else begin
			if (st_r == bfs_pkg::ST_LOCK)
				res_dis_r <= 1'b0;
			else if (res_grounded)
				res_dis_r <= 1'b1;
			if (st_r == bfs_pkg::ST_LOCK || res_dis_r)
				fil_open_r <= 1'b0;
			else if (fil_set)
				fil_open_r <= 1'b1;
			else if (fil_clr)
				fil_open_r <= 1'b0;
		end
	end

	// Lamp inputs are strapped off by grounding during lockout
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lamp_en_r <= 2'h0;
			hs_open_r <= 1'b0;
		end else begin
			if (st_r == bfs_pkg::ST_LOCK)
				lamp_en_r <= {!lamp_sense_second_low,
					!lamp_sense_first_low};
			else if (in_run)
				lamp_en_r <= lamp_en_r | {lamp_sense_second_en_lvl,
					lamp_sense_first_en_lvl};
			// Frozen once the start threshold is passed
			if (st_r == bfs_pkg::ST_LOCK)
				hs_open_r <= 1'b0;
			else if (st_r == bfs_pkg::ST_HYST && !supply_start)
				hs_open_r <= !lamp_snk;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pfc_stop_r <= 1'b0;
			pfc_gate_r <= 1'b0;
			damping_r  <= 1'b0;
		end else begin
			if (ov_run)
				pfc_stop_r <= 1'b1;
			else if (!in_run || !bus_above_resume)
				pfc_stop_r <= 1'b0;
			pfc_gate_r <= pfc_gate_req && pfc_en && !ov_run &&
				!supply_lockout;
			damping_r  <= pfc_en && pfc_dcm_offtime &&
				!pfc_gate_req && !supply_lockout;
		end
	end

	// Fault flags: a set in the clearing cycle wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			end_of_life_fault_r    <= 1'b0;
			rectifier_effect_fault_r    <= 1'b0;
			latched_r <= 1'b0;
			run_r     <= 1'b0;
			preht_r   <= 1'b0;
		end else begin
			if (end_of_life_fault_done)
				end_of_life_fault_r <= 1'b1;
			else if (st_r == bfs_pkg::ST_LOCK || enter_st)
				end_of_life_fault_r <= 1'b0;
			if (rectifier_effect_fault_done)
				rectifier_effect_fault_r <= 1'b1;
			else if (st_r == bfs_pkg::ST_LOCK || enter_st)
				rectifier_effect_fault_r <= 1'b0;
			latched_r <= st_nxt == bfs_pkg::ST_LATCH;
			run_r     <= st_nxt == bfs_pkg::ST_RUN;
			preht_r   <= st_nxt == bfs_pkg::ST_PREHT;
		end
	end

	assign pfc_gate_drive          = pfc_gate_r;
	assign damping_switch          = damping_r;
	assign res_thr_low_sel         = fil_open_r;
	assign res_current_reduced_sel = fil_open_r;
	assign res_current_high_sel    = hs_open_r;
	assign filament_open           = fil_open_r;
	assign end_of_life_fault       = end_of_life_fault_r;
	assign rectifier_effect_fault  = rectifier_effect_fault_r;
	assign latched_fault           = latched_r;
	assign run_mode                = run_r;
	assign preheat_active          = preht_r;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_run_under;
		in_run && !bus_above_under && !res_done && !supply_lockout;
	endsequence

	sequence s_run_eol;
		in_run && end_of_life_fault_done && bus_above_under && !tov_done &&
			!res_done && !retry_r && !supply_lockout;
	endsequence

	a_pfc_ov_stop: assert property (ov_run |=> !pfc_gate_drive)
		else $error("PFC drive not stopped on overvoltage");
	a_pfc_resume: assert property (in_run && pfc_stop_r &&
		!bus_above_ov && !bus_above_resume |=> !pfc_stop_r)
		else $error("PFC stop not released below 105%");
	a_inv_ov: assert property (in_run && tov_done && !res_done &&
		!supply_lockout |=> st_r == bfs_pkg::ST_FUW)
		else $error("inverter overvoltage not handled");
	a_fault_u: assert property (s_run_under |=>
		st_r == bfs_pkg::ST_FUW && fu_cnt_r == 3'h0 && skip_r)
		else $error("fault U entry wrong");
	a_fu_bound: assert property (st_r == bfs_pkg::ST_FUW |->
		fu_cnt_r < FU_MAX)
		else $error("fault U retries exceed seven");
	a_skip_ph: assert property (st_r == bfs_pkg::ST_START &&
		bus_above_start && !supply_lockout |=>
		st_r == ($past(skip_r) ? bfs_pkg::ST_RUN : bfs_pkg::ST_PREHT))
		else $error("preheat skip wrong");
	a_ph_zero: assert property (st_r == bfs_pkg::ST_PREHT &&
		preheat_time_set == 7'h00 && !supply_lockout |=> in_run)
		else $error("zero preheat not immediate");
	a_fil_open: assert property (fil_set |=> fil_open_r)
		else $error("open filament not marked");
	a_start_block: assert property (st_r == bfs_pkg::ST_W130 &&
		fil_open_r |=> st_r != bfs_pkg::ST_START)
		else $error("start with open filament");
	a_res_latch: assert property (in_run && res_done &&
		!supply_lockout |=> st_r == bfs_pkg::ST_LATCH)
		else $error("restart level did not latch");
	a_first_fault: assert property (s_run_eol |=>
		st_r == bfs_pkg::ST_FLTW)
		else $error("first fault not powered down");
	a_latch_hold: assert property (st_r == bfs_pkg::ST_LATCH &&
		!fil_set && !supply_lockout |=> st_r == bfs_pkg::ST_LATCH)
		else $error("latched fault left early");
	a_res_off: assert property (res_dis_r |=> !fil_open_r)
		else $error("disabled restart pin still active");
	a_lockout: assert property (supply_lockout |=>
		!pfc_gate_drive && st_r == bfs_pkg::ST_LOCK ##1
		!upper_gate_drive && !lower_gate_drive)
		else $error("gates active in lockout");

endmodule : bfs_supervisor

// ### dv/bfs_stage.sv
`timescale 1ns/1ps

module bfs_stage #(
	parameter int VLY = 140
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] bus_pct,
	input  wire logic       upper_gate_drive,
	input  wire logic       lower_gate_drive,
	output logic            bus_above_open,
	output logic            bus_above_under,
	output logic            bus_above_start,
	output logic            bus_above_resume,
	output logic            bus_above_ov,
	output logic            bridge_valley
);
	logic [8:0] off_cnt_r;
	logic       ov_r;

	// Bus in whole percent of rated level
	assign bus_above_open   = (bus_pct > 8'h0C);
	assign bus_above_under  = (bus_pct > 8'h4B);
	assign bus_above_start  = (bus_pct > 8'h5E);
	assign bus_above_resume = (bus_pct > 8'h68);
	assign bus_above_ov     = ov_r;
	// Node rings down only while both switches are off
	assign bridge_valley    = (int'(off_cnt_r) >= VLY);

	// Overvoltage comparator keeps its 4 percent hysteresis
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ov_r      <= 1'b0;
			off_cnt_r <= 9'h000;
		end else begin
			if (bus_pct > 8'h6C)
				ov_r <= 1'b1;
			else if (bus_pct < 8'h69)
				ov_r <= 1'b0;
			if (upper_gate_drive || lower_gate_drive)
				off_cnt_r <= 9'h000;
			else if (off_cnt_r != 9'h1FF)
				off_cnt_r <= off_cnt_r + 9'h001;
		end
	end
endmodule : bfs_stage

// ### dv/bfs_supervisor_tb.sv
`timescale 1ns/1ps

module bfs_supervisor_tb;
	localparam int TK = 125;
	localparam int T130 = 3, T620 = 5, TFU = 6, TFLT = 10, TDC = 15, PHS = 2;
	localparam int TOV = 12;
	localparam int UG = 0, LG = 1, PG = 2, DS = 3, FO = 4, EO = 5, RE = 6;
	localparam int LF = 7, RM = 8, HS = 9;
	logic mclk, rst_n, supply_lockout, supply_start, res_above_thr;
	logic res_above_latch, res_grounded, sink1, sink2, ac1, dc1, dc2;
	logic ac2, low1, en1;
	logic half_bridge_phase, pfc_gate_req, pfc_dcm_offtime;
	logic [6:0] preheat_time_set;
	logic [7:0] bus_pct;
	logic b_open, b_under, b_start, b_resume, b_ov, valley;
	logic upper, lower, pfc, damp, thr_low, cur_high, cur_red, fil_open;
	logic eol, rect, latched, run_mode, preheat;
	logic [9:0] mon;
	int bad_count, cmp_count, ph_cnt, c;

	assign mon = {cur_high, run_mode, latched, rect, eol, fil_open, damp,
		pfc, lower, upper};

	bfs_supervisor #(.T_130(22'(T130)), .T_620(22'(T620)), .T_80(22'h8),
		.T_FU(22'(TFU)), .T_FLT(22'(TFLT)), .T_OV(22'(TOV)),
		.T_DC(22'(TDC)), .PH_STP(22'(PHS))) i_bfs_supervisor (
		.mclk(mclk), .rst_n(rst_n), .supply_lockout(supply_lockout),
		.supply_start(supply_start), .bus_above_open(b_open),
		.bus_above_under(b_under), .bus_above_start(b_start),
		.bus_above_resume(b_resume), .bus_above_ov(b_ov),
		.res_above_thr(res_above_thr), .res_above_latch(res_above_latch),
		.res_grounded(res_grounded), .lamp_sense_first_sink(sink1),
		.lamp_sense_second_sink(sink2), .lamp_sense_first_low(low1),
		.lamp_sense_second_low(1'b0), .lamp_sense_first_en_lvl(en1),
		.lamp_sense_second_en_lvl(1'b0), .lamp_sense_first_ac_over(ac1),
		.lamp_sense_second_ac_over(ac2), .lamp_sense_first_dc_over(dc1),
		.lamp_sense_second_dc_over(dc2), .preheat_time_set(preheat_time_set),
		.half_bridge_phase(half_bridge_phase), .bridge_valley(valley),
		.pfc_gate_req(pfc_gate_req), .pfc_dcm_offtime(pfc_dcm_offtime),
		.upper_gate_drive(upper), .lower_gate_drive(lower),
		.pfc_gate_drive(pfc), .damping_switch(damp),
		.res_thr_low_sel(thr_low), .res_current_high_sel(cur_high),
		.res_current_reduced_sel(cur_red), .filament_open(fil_open),
		.end_of_life_fault(eol), .rectifier_effect_fault(rect),
		.latched_fault(latched), .run_mode(run_mode),
		.preheat_active(preheat));

	bfs_stage i_bfs_stage (.mclk(mclk), .rst_n(rst_n), .bus_pct(bus_pct),
		.upper_gate_drive(upper), .lower_gate_drive(lower),
		.bus_above_open(b_open), .bus_above_under(b_under),
		.bus_above_start(b_start), .bus_above_resume(b_resume),
		.bus_above_ov(b_ov), .bridge_valley(valley));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (preheat === 1'b1)
			ph_cnt++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for one watched output, then judge it
	task automatic wb(input int i, input logic v, input int n);
		c = 0;
		while (mon[i] !== v && c < n) begin
			@(negedge mclk);
			c++;
		end
		chk(mon[i], v);
	endtask : wb

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task automatic t_start();
		repeat (50) @(negedge mclk);
		chk({upper, lower, pfc}, 3'h0);
		supply_lockout = 1'b0;
		// Stay below the start threshold long enough to sample lamp sinks
		repeat (5) @(negedge mclk);
		supply_start = 1'b1;
		ph_cnt = 0;
		wb(RM, 1'b1, 3000);
		chk(c >= T130 * TK, 1'b1);
		chk(ph_cnt >= (2 * PHS - 1) * TK && ph_cnt <= (2 * PHS + 1) * TK, 1);
		chk(cur_high, 1'b0);
	endtask : t_start

	task automatic t_pfc();
		pfc_gate_req = 1'b1;
		wb(PG, 1'b1, 10);
		bus_pct = 8'h6E;
		wb(PG, 1'b0, 625);
		bus_pct = 8'h6A;
		repeat (20) @(negedge mclk);
		chk({pfc, run_mode}, 2'b01);
		bus_pct = 8'h64;
		wb(PG, 1'b1, 10);
		pfc_gate_req = 1'b0;
		repeat (5) @(negedge mclk);
		chk(damp, 1'b0);
		pfc_dcm_offtime = 1'b1;
		wb(DS, 1'b1, 5);
		pfc_gate_req = 1'b1;
		wb(DS, 1'b0, 5);
		pfc_dcm_offtime = 1'b0;
		bus_pct = 8'h6E;
		wb(RM, 1'b0, 1700);
		chk(c >= (TOV - 1) * TK - 5, 1'b1);
		@(negedge mclk);
		chk({upper, lower, pfc}, 3'h0);
		bus_pct = 8'h64;
		ph_cnt = 0;
		wb(RM, 1'b1, 3000);
		chk(ph_cnt, 0);
	endtask : t_pfc

	// Gap from one gate falling to the other rising
	task automatic t_dead(input logic p);
		int g;
		half_bridge_phase = p;
		wb(p ? LG : UG, 1'b0, 10);
		g = 0;
		while (mon[p ? UG : LG] !== 1'b1 && g < 400) begin
			@(negedge mclk);
			g++;
		end
		chk(g >= 132 && g <= 250, 1'b1);
	endtask : t_dead

	task automatic t_fault_u();
		bus_pct = 8'h46;
		wb(RM, 1'b0, 10);
		// Gates drop one edge after the state leaves run
		@(negedge mclk);
		chk({upper, lower}, 2'b00);
		bus_pct = 8'h64;
		ph_cnt = 0;
		wb(RM, 1'b1, 3000);
		chk(c >= (TFU - 1) * TK, 1'b1);
		chk(ph_cnt, 0);
	endtask : t_fault_u

	task automatic t_eol();
		ac2 = 1'b1;
		wb(EO, 1'b1, 900);
		chk(c >= (T620 - 1) * TK, 1'b1);
		ac2 = 1'b0;
		wb(RM, 1'b0, 5);
		@(negedge mclk);
		chk({upper, lower}, 2'b00);
		ph_cnt = 0;
		wb(RM, 1'b1, 3000);
		chk(c >= (TFLT - 1) * TK && ph_cnt > 0, 1'b1);
	endtask : t_eol

	// Latch, then a fresh open-filament crossing counts as lamp removal
	task automatic t_latch();
		res_above_latch = 1'b1;
		wb(LF, 1'b1, 900);
		chk(c >= (T620 - 1) * TK, 1'b1);
		res_above_latch = 1'b0;
		repeat (2000) @(negedge mclk);
		chk({latched, upper, lower}, 3'h4);
		res_above_thr = 1'b1;
		wb(FO, 1'b1, 10);
		wb(LF, 1'b0, 10);
		chk({thr_low, cur_red}, 2'b11);
		repeat (1000) @(negedge mclk);
		chk(run_mode, 1'b0);
		res_above_thr = 1'b0;
		wb(FO, 1'b0, 10);
		wb(RM, 1'b1, 3000);
	endtask : t_latch

	task automatic t_dc();
		dc1 = 1'b1;
		dc2 = 1'b1;
		wb(RE, 1'b1, 2100);
		chk(c >= (TDC - 1) * TK, 1'b1);
		dc1 = 1'b0;
		dc2 = 1'b0;
		wb(RM, 1'b0, 5);
	endtask : t_dc

	task automatic t_fin();
		wb(RM, 1'b1, 3000);
		supply_lockout = 1'b1;
		supply_start = 1'b0;
		sink1 = 1'b0;
		sink2 = 1'b0;
		low1 = 1'b1;
		wb(RM, 1'b0, 3);
		chk({upper, lower, pfc}, 3'h0);
		repeat (3) @(negedge mclk);
		supply_lockout = 1'b0;
		res_grounded = 1'b1;
		repeat (5) @(negedge mclk);
		res_grounded = 1'b0;
		res_above_thr = 1'b1;
		supply_start = 1'b1;
		wb(RM, 1'b1, 3000);
		chk({fil_open, cur_high}, 2'b01);
		// First lamp input was strapped off; only its enable level wakes it
		ac1 = 1'b1;
		repeat (1000) @(negedge mclk);
		chk({eol, run_mode}, 2'b01);
		en1 = 1'b1;
		wb(EO, 1'b1, 900);
		{ac1, en1} = 2'h0;
	endtask : t_fin

	initial begin
		{supply_start, res_above_thr, res_above_latch, res_grounded} = 4'h0;
		{ac1, dc1, dc2, half_bridge_phase, pfc_gate_req} = 5'h00;
		{ac2, low1, en1} = 3'h0;
		pfc_dcm_offtime = 1'b0;
		{sink1, sink2, supply_lockout} = 3'h7;
		preheat_time_set = 7'h02;
		bus_pct = 8'h64;
		bad_count = 0;
		cmp_count = 0;
		ph_cnt = 0;
		rst_n = 1'b0;
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		t_start();
		t_pfc();
		t_dead(1'b1);
		t_dead(1'b0);
		t_fault_u();
		t_eol();
		t_latch();
		t_dc();
		t_fin();
		conclude();
	end

	// About three times the expected run length
	initial begin
		#400000;
		bad_count++;
		conclude();
	end
endmodule : bfs_supervisor_tb
